// [verilog/cid_pkg.sv]
// constants and carriers of the curtain indicator decoder
// assumes one 100 MHz system clock shared with the sensing logic
package cid_pkg;

  // ==========================================================
  // clock and blink timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned BLINK_PERIOD_MS = 500;
  localparam int unsigned BLINK_HALF_CYC  = BLINK_PERIOD_MS * (CLK_HZ / 1000) / 2;
  localparam int unsigned BLINK_CNT_W     = 25;

  // ==========================================================
  // register map, byte addresses
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_INT_STAT = 8'h08;
  localparam logic [7:0]  REG_INT_MASK = 8'h0c;

  // control fields and reset values
  localparam int unsigned CTRL_ERR_EN_BIT = 0;
  localparam logic        CTRL_ERR_EN_RST = 1'b1;
  localparam logic [4:0]  INT_MASK_RST    = 5'h00;

  // interrupt event bits
  localparam int unsigned INT_W       = 5;
  localparam int unsigned INT_SSW_ON  = 0;
  localparam int unsigned INT_SSW_OFF = 1;
  localparam int unsigned INT_FAULT   = 2;
  localparam int unsigned INT_LOCKOUT = 3;
  localparam int unsigned INT_MARGIN  = 4;

  // segment positions inside the lamp vectors
  localparam int unsigned SEG_TOP = 3;
  localparam int unsigned SEG_UMD = 2;
  localparam int unsigned SEG_LMD = 1;
  localparam int unsigned SEG_BOT = 0;

  // light-margin thresholds in percent of the switch-on level
  localparam logic [7:0] PCT_REF    = 8'h64;
  localparam logic [7:0] PCT_STABLE = 8'h73;
  localparam logic [7:0] PCT_GREEN  = 8'h82;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [3:0]  seg_lit;
    logic        top_end;
    logic        bot_end;
    logic        ssw_on;
    logic        blocked;
    logic [15:0] intensity;
    logic [15:0] on_thresh;
    logic        fault;
    logic        fault_blink;
    logic        lockout;
    logic [7:0]  err_code;
    logic        pnp;
    logic        short_mode;
    logic        emit_halt;
    logic        blanking;
    logic        hc_conn;
    logic        interlock;
  } cid_sense_t;

  typedef struct packed {
    logic [3:0] seg_red;
    logic [3:0] seg_green;
    logic       out_red;
    logic       out_green;
    logic       mrg_green;
    logic       mrg_orange;
    logic       fault;
    logic       err_show;
    logic [7:0] err_code;
    logic       pnp;
    logic       npn;
    logic       level;
    logic       halt;
    logic       func;
    logic       ilock;
  } cid_lamp_t;

  typedef struct packed {
    logic [BLINK_CNT_W-1:0] blink_cnt;
    logic                   blink_ph;
    cid_lamp_t              lamps;
    logic                   err_en;
    logic [INT_W-1:0]       int_stat;
    logic [INT_W-1:0]       int_mask;
    logic [31:0]            rd_data;
    logic                   prev_ssw;
    logic                   prev_fault;
    logic                   prev_lock;
    logic                   prev_orange;
  } cid_state_t;

  localparam cid_state_t ST_RST = '{err_en: CTRL_ERR_EN_RST, int_mask: INT_MASK_RST,
                                    default: '0};

endpackage : cid_pkg

// [verilog/cid_decoder.sv]
// front panel lamp decoder of a safety light curtain, with register port
// assumes all sense inputs come from logic on SYS_CLK, so no synchroniser
module cid_decoder
  import cid_pkg::*;
#(
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
) (
  // clock, reset, enable
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              CE,
  // sensing state
  input  wire cid_sense_t        SENSE,
  // register port
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [31:0]       WR_DATA,
  input  wire logic              WR_EN,
  input  wire logic              RD_EN,
  output logic      [31:0]       RD_DATA,
  // panel lamps
  output cid_lamp_t              LAMPS,
  // interrupt
  output logic                   IRQ
);

  // ==========================================================
  // state
  cid_state_t s_reg;
  cid_state_t s_next;

  logic [31:0] lvl_now;
  logic [31:0] lvl_ref;
  logic [31:0] lvl_stable;
  logic [31:0] lvl_green;
  logic        orange_now;
  logic [INT_W-1:0] ev;
  logic [INT_W-1:0] clr;

  // ==========================================================
  // light margin, cross-multiplied so no divider is needed
  always_comb begin
    lvl_now    = 32'(SENSE.intensity) * 32'(PCT_REF);
    lvl_ref    = 32'(SENSE.on_thresh) * 32'(PCT_REF);
    lvl_stable = 32'(SENSE.on_thresh) * 32'(PCT_STABLE);
    lvl_green  = 32'(SENSE.on_thresh) * 32'(PCT_GREEN);
    orange_now = !SENSE.blocked && lvl_now >= lvl_ref && lvl_now < lvl_stable;
  end

  // ==========================================================
  // next state
  always_comb begin
    s_next = s_reg;
    ev     = '0;
    clr    = '0;
    if (CE) begin
      if (s_reg.blink_cnt == BLINK_CNT_W'(BLINK_HALF - 1)) begin
        s_next.blink_cnt = '0;
        s_next.blink_ph  = !s_reg.blink_ph;
      end else begin
        s_next.blink_cnt = s_reg.blink_cnt + 1'b1;
      end

      s_next.lamps.seg_red   = SENSE.seg_lit;
      s_next.lamps.seg_green = '0;
      if (SENSE.top_end) begin
        s_next.lamps.seg_red[SEG_TOP] = s_reg.blink_ph;
      end
      if (SENSE.bot_end) begin
        s_next.lamps.seg_red[SEG_BOT] = s_reg.blink_ph;
      end
      if (SENSE.ssw_on) begin
        s_next.lamps.seg_red   = '0;
        s_next.lamps.seg_green = '1;
      end

      s_next.lamps.out_green = SENSE.ssw_on;
      s_next.lamps.out_red   = !SENSE.ssw_on;

      s_next.lamps.mrg_green  = !SENSE.blocked && lvl_now >= lvl_green;
      s_next.lamps.mrg_orange = orange_now;

      s_next.lamps.fault = SENSE.fault && (!SENSE.fault_blink || s_reg.blink_ph);
      s_next.lamps.err_show = SENSE.lockout && s_reg.err_en;
      s_next.lamps.err_code = (SENSE.lockout && s_reg.err_en) ? SENSE.err_code : 8'h00;
      s_next.lamps.pnp = SENSE.pnp;
      s_next.lamps.npn = !SENSE.pnp;
      s_next.lamps.level = SENSE.short_mode && !SENSE.emit_halt;
      s_next.lamps.halt  = SENSE.emit_halt;
      // blink while controller attached, else steady on blanking
      s_next.lamps.func = SENSE.hc_conn ? s_reg.blink_ph : SENSE.blanking;
      s_next.lamps.ilock = SENSE.interlock;

      // events; a set in the clearing cycle survives
      ev[INT_SSW_ON]  = SENSE.ssw_on && !s_reg.prev_ssw;
      ev[INT_SSW_OFF] = !SENSE.ssw_on && s_reg.prev_ssw;
      ev[INT_FAULT]   = SENSE.fault && !s_reg.prev_fault;
      ev[INT_LOCKOUT] = SENSE.lockout && !s_reg.prev_lock;
      ev[INT_MARGIN]  = orange_now && !s_reg.prev_orange;
      s_next.prev_ssw    = SENSE.ssw_on;
      s_next.prev_fault  = SENSE.fault;
      s_next.prev_lock   = SENSE.lockout;
      s_next.prev_orange = orange_now;

      // register writes
      if (WR_EN) begin
        case (ADDR)
          REG_CTRL:     s_next.err_en = WR_DATA[CTRL_ERR_EN_BIT];
          REG_INT_STAT: clr = WR_DATA[INT_W-1:0];
          REG_INT_MASK: s_next.int_mask = WR_DATA[INT_W-1:0];
          default:      ;
        endcase
      end
      s_next.int_stat = (s_reg.int_stat & ~clr) | ev;

      // register reads, unmapped reads give zero
      s_next.rd_data = '0;
      if (RD_EN) begin
        case (ADDR)
          REG_CTRL:     s_next.rd_data = {31'h0, s_reg.err_en};
          REG_STATUS:   s_next.rd_data = 32'(s_reg.lamps);
          REG_INT_STAT: s_next.rd_data = 32'(s_reg.int_stat);
          REG_INT_MASK: s_next.rd_data = 32'(s_reg.int_mask);
          default:      s_next.rd_data = '0;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      s_reg <= ST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign LAMPS   = s_reg.lamps;
  assign RD_DATA = s_reg.rd_data;
  assign IRQ     = |(s_reg.int_stat & s_reg.int_mask);

  // ==========================================================
  // checks
  a_seg_green_on: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && SENSE.ssw_on |=> LAMPS.seg_green == 4'hf)
    else $error("segment lamps not green while output on");

  a_green_wins: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && SENSE.ssw_on && (SENSE.seg_lit != 4'h0) |=> LAMPS.seg_red == 4'h0)
    else $error("red segment shown while output on");

  a_seg_red_lit: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.ssw_on && !SENSE.top_end && SENSE.seg_lit[SEG_TOP]
    |=> LAMPS.seg_red[SEG_TOP] && !LAMPS.seg_green[SEG_TOP])
    else $error("top segment not steady red");

  a_upper_mid: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.ssw_on |=> LAMPS.seg_red[SEG_UMD] == $past(SENSE.seg_lit[SEG_UMD]))
    else $error("upper middle lamp wrong");

  a_end_blink: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.ssw_on && SENSE.bot_end
    |=> LAMPS.seg_red[SEG_BOT] == $past(s_reg.blink_ph))
    else $error("bottom lamp not following blink");

  a_out_lamp: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE |=> LAMPS.out_green == $past(SENSE.ssw_on) && LAMPS.out_red != LAMPS.out_green)
    else $error("output lamp colour wrong");

  a_margin_green: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.blocked && lvl_now >= lvl_green |=> LAMPS.mrg_green && !LAMPS.mrg_orange)
    else $error("margin lamp not green");

  a_margin_mid: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && lvl_now >= lvl_stable && lvl_now < lvl_green
    |=> !LAMPS.mrg_green && !LAMPS.mrg_orange)
    else $error("margin lamp lit in stable band");

  a_margin_orange: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.blocked && lvl_now >= lvl_ref && lvl_now < lvl_stable
    |=> LAMPS.mrg_orange && !LAMPS.mrg_green)
    else $error("margin lamp not orange");

  a_margin_block: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && SENSE.blocked |=> !LAMPS.mrg_green && !LAMPS.mrg_orange)
    else $error("margin lamp lit while blocked");

  a_fault_lamp: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && SENSE.fault && !SENSE.fault_blink |=> LAMPS.fault)
    else $error("fault lamp dark on fault");

  a_err_show: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && SENSE.lockout && s_reg.err_en
    |=> LAMPS.err_show && LAMPS.err_code == $past(SENSE.err_code))
    else $error("error code not shown in lockout");

  a_polarity_one: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE |=> LAMPS.pnp == $past(SENSE.pnp) && LAMPS.npn == !LAMPS.pnp)
    else $error("polarity lamps wrong");

  a_level_lamp: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.short_mode |=> !LAMPS.level)
    else $error("level lamp lit in normal mode");

  a_halt_lamp: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE |=> LAMPS.halt == $past(SENSE.emit_halt))
    else $error("halt lamp wrong");

  a_func_lamp: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.hc_conn |=> LAMPS.func == $past(SENSE.blanking))
    else $error("function lamp not steady on blanking");

  a_ilock_lamp: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE ##1 CE |=> LAMPS.ilock == $past(SENSE.interlock))
    else $error("interlock lamp wrong");

  a_blink_half: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $changed(s_reg.blink_ph) |-> $past(s_reg.blink_cnt) == BLINK_CNT_W'(BLINK_HALF - 1))
    else $error("blink phase changed off schedule");

  a_irq_level: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !WR_EN && ev[INT_LOCKOUT] && s_reg.int_mask[INT_LOCKOUT] |=> IRQ)
    else $error("unmasked event raised no interrupt");

  // ==========================================================
  // further lamp checks
  a_seg_red_bot: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.ssw_on && !SENSE.bot_end && SENSE.seg_lit[SEG_BOT]
    |=> LAMPS.seg_red[SEG_BOT] && !LAMPS.seg_green[SEG_BOT])
    else $error("bottom segment not steady red");

  a_lower_mid: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.ssw_on |=> LAMPS.seg_red[SEG_LMD] == $past(SENSE.seg_lit[SEG_LMD]))
    else $error("lower middle lamp wrong");

  a_top_blink: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.ssw_on && SENSE.top_end
    |=> LAMPS.seg_red[SEG_TOP] == $past(s_reg.blink_ph))
    else $error("top lamp not following blink");

  a_no_green_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.ssw_on |=> LAMPS.seg_green == 4'h0)
    else $error("segment lamp green while output off");

  a_green_all: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && SENSE.ssw_on && (SENSE.top_end || SENSE.bot_end)
    |=> LAMPS.seg_red == 4'h0 && LAMPS.seg_green == 4'hf)
    else $error("end blink shown while output on");

  a_red_when_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.ssw_on |=> LAMPS.out_red && !LAMPS.out_green)
    else $error("output lamp not red while off");

  a_margin_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && lvl_now < lvl_ref |=> !LAMPS.mrg_green && !LAMPS.mrg_orange)
    else $error("margin lamp lit below switch-on level");

  a_margin_excl: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE |=> !(LAMPS.mrg_green && LAMPS.mrg_orange))
    else $error("margin lamp both colours");

  a_fault_dark: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.fault |=> !LAMPS.fault)
    else $error("fault lamp lit without fault");

  a_fault_blink: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && SENSE.fault && SENSE.fault_blink
    |=> LAMPS.fault == $past(s_reg.blink_ph))
    else $error("fault lamp not following blink");

  a_err_hidden: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.lockout |=> !LAMPS.err_show && LAMPS.err_code == 8'h00)
    else $error("error code shown outside lockout");

  a_polarity_excl: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE |=> LAMPS.pnp != LAMPS.npn)
    else $error("polarity lamps not exclusive");

  a_level_on: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && SENSE.short_mode && !SENSE.emit_halt |=> LAMPS.level)
    else $error("level lamp dark in short mode");

  a_func_blink: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && SENSE.hc_conn |=> LAMPS.func == $past(s_reg.blink_ph))
    else $error("function lamp not blinking");

  a_ilock_dark: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !SENSE.interlock |=> !LAMPS.ilock)
    else $error("interlock lamp lit when not interlocked");

  // ==========================================================
  // register, interrupt, enable and reset checks
  a_w1c_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && WR_EN && ADDR == REG_INT_STAT && ev == 5'h00
    |=> (s_reg.int_stat & $past(WR_DATA[INT_W-1:0])) == 5'h00)
    else $error("status bit not cleared by write of one");

  a_stat_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !WR_EN
    |=> (s_reg.int_stat & $past(s_reg.int_stat)) == $past(s_reg.int_stat))
    else $error("status bit dropped without write");

  a_set_wins: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE |=> (s_reg.int_stat & $past(ev)) == $past(ev))
    else $error("event lost in status register");

  a_mask_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && WR_EN && ADDR == REG_INT_MASK
    |=> s_reg.int_mask == $past(WR_DATA[INT_W-1:0]))
    else $error("mask write not taken");

  a_ctrl_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && WR_EN && ADDR == REG_CTRL
    |=> s_reg.err_en == $past(WR_DATA[CTRL_ERR_EN_BIT]))
    else $error("control write not taken");

  a_rd_stat: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && RD_EN && ADDR == REG_INT_STAT
    |=> RD_DATA == 32'($past(s_reg.int_stat)))
    else $error("status read wrong");

  a_rd_status: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && RD_EN && ADDR == REG_STATUS
    |=> RD_DATA == 32'($past(s_reg.lamps)))
    else $error("lamp status read wrong");

  a_rd_unmapped: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && RD_EN && ADDR > REG_INT_MASK |=> RD_DATA == 32'h0)
    else $error("unmapped read not zero");

  a_rd_idle: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && !RD_EN |=> RD_DATA == 32'h0)
    else $error("read data stands past its cycle");

  a_irq_fall: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CE && WR_EN && ADDR == REG_INT_STAT && WR_DATA[INT_W-1:0] == 5'h1f && ev == 5'h00
    |=> !IRQ)
    else $error("interrupt stays after full clear");

  a_freeze_ce: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !CE |=> $stable(s_reg))
    else $error("state moved while enable low");

  a_reset_state: assert property (@(posedge SYS_CLK)
    !RST_N |=> LAMPS == cid_lamp_t'(0) && RD_DATA == 32'h0 && !IRQ)
    else $error("outputs not cleared by reset");

endmodule : cid_decoder

// [sim/cid_panel_viewer.sv]
// operator model: watches the front panel lamps and times how long they stay still
// assumes lamps change only on rising edges of the system clock
module cid_panel_viewer
  import cid_pkg::*;
(
  // clock and panel
  input  wire logic      sys_clk,
  input  wire cid_lamp_t lamps,
  // cycles between the last two panel changes
  output int             gap
);
  timeunit 1ns;
  timeprecision 1ps;

  cid_lamp_t seen;
  int        run;

  initial begin
    seen = '0;
    run  = 0;
    gap  = 0;
  end

  // ==========================================================
  // change timing
  // an operator sees only changes, so a steady blink gives a fixed gap
  always @(posedge sys_clk) begin
    if (lamps !== seen) begin
      gap <= run + 1;
      run <= 0;
    end else begin
      run <= run + 1;
    end
    seen <= lamps;
  end
endmodule : cid_panel_viewer

// [sim/test_curtain_indicator_decoder.sv]
// self-checking bench of the curtain indicator decoder
// assumes a short blink half period so blink timing fits a short run
module test_curtain_indicator_decoder;
  import cid_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned HALF = 4;

  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        ce      = 1'b1;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] rd_data;
  logic        irq;
  cid_sense_t  sense   = '0;
  cid_sense_t  s;
  cid_lamp_t   lamps;
  cid_lamp_t   e;
  int          err_total   = 0;
  int          check_count = 0;
  int          gap;

  cid_decoder #(.BLINK_HALF(HALF)) dut_u (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .CE(ce), .SENSE(sense), .ADDR(addr),
    .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
    .LAMPS(lamps), .IRQ(irq));

  cid_panel_viewer view_u (.sys_clk(sys_clk), .lamps(lamps), .gap(gap));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apply(input cid_sense_t v);
    @(posedge sys_clk);
    sense <= v;
    @(posedge sys_clk);
    #1;
  endtask : apply

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
  endtask : wr

  // read data must stand one cycle only, then fall back to zero
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 check(rd_data, exp);
    @(posedge sys_clk);
    #1 check(rd_data, 32'h0);
  endtask : rd

  function automatic cid_sense_t base();
    cid_sense_t v;
    v           = '0;
    v.on_thresh = 16'h0064;
    return v;
  endfunction : base

  function automatic cid_lamp_t idle();
    cid_lamp_t v;
    v         = '0;
    v.out_red = 1'b1;
    v.npn     = 1'b1;
    return v;
  endfunction : idle

  // ==========================================================
  // scenarios
  task automatic sc_segments();
    for (int i = 0; i < 4; i++) begin
      s = base();
      s.seg_lit = 4'h1 << i;
      apply(s);
      e = idle();
      e.seg_red = 4'h1 << i;
      check({4'h0, lamps}, {4'h0, e});
    end
  endtask : sc_segments

  task automatic sc_output();
    s = base();
    s.seg_lit = 4'hf;
    s.top_end = 1'b1;
    s.bot_end = 1'b1;
    s.ssw_on  = 1'b1;
    apply(s);
    e = idle();
    e.seg_green = 4'hf;
    e.out_red   = 1'b0;
    e.out_green = 1'b1;
    check({4'h0, lamps}, {4'h0, e});
  endtask : sc_output

  task automatic sc_margin();
    logic [15:0] lvl [7] = '{16'h0082, 16'h0081, 16'h0073, 16'h0072, 16'h0064, 16'h0063,
                             16'h008c};
    logic [1:0]  exp [7] = '{2'h2, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0};
    for (int i = 0; i < 7; i++) begin
      s = base();
      s.intensity = lvl[i];
      s.blocked   = (i == 6);
      apply(s);
      check({30'h0, lamps.mrg_green, lamps.mrg_orange}, {30'h0, exp[i]});
    end
  endtask : sc_margin

  task automatic sc_misc();
    s = base();
    s.fault      = 1'b1;
    s.lockout    = 1'b1;
    s.err_code   = 8'h5a;
    s.pnp        = 1'b1;
    s.short_mode = 1'b1;
    s.blanking   = 1'b1;
    s.interlock  = 1'b1;
    apply(s);
    e = idle();
    e.fault    = 1'b1;
    e.err_show = 1'b1;
    e.err_code = 8'h5a;
    e.pnp      = 1'b1;
    e.npn      = 1'b0;
    e.level    = 1'b1;
    e.func     = 1'b1;
    e.ilock    = 1'b1;
    check({4'h0, lamps}, {4'h0, e});
    s.emit_halt = 1'b1;
    apply(s);
    e.halt  = 1'b1;
    e.level = 1'b0;
    check({4'h0, lamps}, {4'h0, e});
  endtask : sc_misc

  // one blinking source at a time; the operator times the panel changes
  task automatic sc_blink();
    for (int i = 0; i < 4; i++) begin
      s = base();
      case (i)
        0: begin s.top_end = 1'b1; s.seg_lit = 4'h8; end
        1: begin s.bot_end = 1'b1; s.seg_lit = 4'h1; end
        2: begin s.hc_conn = 1'b1; s.blanking = 1'b1; end
        default: begin s.fault = 1'b1; s.fault_blink = 1'b1; end
      endcase
      apply(s);
      repeat (20) @(posedge sys_clk);
      check(gap, HALF);
    end
  endtask : sc_blink

  task automatic sc_regs();
    apply(base());
    rd(REG_CTRL, 32'h1);
    rd(REG_INT_MASK, 32'h0);
    wr(REG_INT_STAT, 32'h1f);
    wr(REG_INT_MASK, 32'h08);
    s = base();
    s.lockout = 1'b1;
    apply(s);
    @(posedge sys_clk);
    #1 check({31'h0, irq}, 32'h1);
    s.ssw_on = 1'b1;
    apply(s);
    @(posedge sys_clk);
    rd(REG_INT_STAT, 32'h09);
    wr(REG_INT_STAT, 32'h08);
    rd(REG_INT_STAT, 32'h01);
    #1 check({31'h0, irq}, 32'h0);
    e = idle();
    e.out_red   = 1'b0;
    e.out_green = 1'b1;
    e.seg_green = 4'hf;
    e.err_show  = 1'b1;
    wr(REG_STATUS, 32'hffffffff);
    rd(REG_STATUS, {4'h0, e});
    rd(8'h10, 32'h0);
    wr(REG_CTRL, 32'h0);
    rd(REG_CTRL, 32'h0);
    e.err_show = 1'b0;
    check({4'h0, lamps}, {4'h0, e});
  endtask : sc_regs

  // enable low must hold the panel, release lets it follow again
  task automatic sc_freeze();
    s = base();
    s.interlock = 1'b1;
    @(posedge sys_clk);
    ce <= 1'b0;
    e = lamps;
    apply(s);
    check({4'h0, lamps}, {4'h0, e});
    @(posedge sys_clk);
    ce <= 1'b1;
    @(posedge sys_clk);
    #1 check({31'h0, lamps.ilock}, 32'h1);
  endtask : sc_freeze

  // ==========================================================
  // verdict
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    sc_segments();
    sc_output();
    sc_margin();
    sc_misc();
    sc_blink();
    sc_regs();
    sc_freeze();
    tally_and_finish();
  end

  // hang guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    tally_and_finish();
  end
endmodule : test_curtain_indicator_decoder
